// *** rtl/rai_pkg.sv ***
package rai_pkg;

  // source numbering, bit i of the candidate vector is source i
  localparam int NSRC = 24;
  localparam int IDX_W = 5;
  localparam int SRC_SOFT = 0;
  localparam int SRC_TRAP = 2;
  localparam int SRC_WDT = 3;
  localparam int SRC_FIRST_MASK = 4;
  localparam int SRC_EXT0 = 4;
  localparam int SRC_HI_FIRST = 16;

  // vectors and levels
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SOFT = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP = 16'hFFFA;
  localparam logic [15:0] VEC_WDT = 16'hFFF8;
  localparam logic [15:0] VEC_LO_BASE = 16'hFFF6;
  localparam logic [15:0] VEC_HI_BASE = 16'hFFBE;
  localparam logic [4:0] LEVEL_RESET = 5'h01;
  localparam logic [4:0] LEVEL_NMI = 5'h02;

  // timing, oscillator and clk are the same 100 MHz source
  localparam int CLK_NS = 10;
  localparam int FC_NS = 10;
  localparam int MALF_RST_FC = 24;
  localparam int MALF_RST_CYC = (MALF_RST_FC * FC_NS) / CLK_NS;
  localparam int EXT_RST_MIN_FC = 12;
  localparam int EXT_RST_MIN_CYC = (EXT_RST_MIN_FC * FC_NS + CLK_NS - 1) / CLK_NS;

  // register byte offsets
  localparam logic [7:0] REG_LATCH = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_SYSCTL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // watchdog_control_one fields
  localparam int CTL_W = 5;
  localparam int CTL_TRAP_RAM = 0;
  localparam int CTL_TRAP_ACT = 1;
  localparam int CTL_WDT_ACT = 2;
  localparam int CTL_EXT0_EN = 3;
  localparam int CTL_WDT_EN = 4;
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h16;

  // system_control_two fields
  localparam int SYS_W = 3;
  localparam int SYS_XEN = 0;
  localparam int SYS_XTEN = 1;
  localparam int SYS_SYSCK = 2;
  localparam logic [SYS_W-1:0] SYS_RESET = 3'h1;

  // enable and status fields
  localparam int EN_IMF = 0;
  localparam int ST_REQ = 0;
  localparam int ST_LEVEL = 1;
  localparam int ST_CAUSE = 8;

  typedef struct packed {
    logic valid;
    logic in_sfr;
    logic in_dbr;
    logic in_ram;
  } rai_fetch_t;

  typedef struct packed {
    logic accept;
    logic reti;
  } rai_ack_t;

  typedef struct packed {
    logic req;
    logic nmi;
    logic [4:0] level;
    logic [15:0] vector;
  } rai_irq_t;

endpackage

// *** rtl/rai_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module rai_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** rtl/rai_prio.sv ***
`timescale 1ns/1ps
`default_nettype none
module rai_prio #(
  parameter int N = 24,
  parameter int IW = 5
) (
  // candidates, lowest index wins
  input wire logic [N-1:0] req,
  // selection
  output logic valid,
  output logic [IW-1:0] idx
);
  logic [N:0] none;
  logic [N-1:0] hit;

  if (N > (1 << IW)) begin : g_bad_width
    $error("rai_prio: index width too small");
  end

  assign none[0] = 1'b1;
  for (genvar i = 0; i < N; i++) begin : g_chain
    assign hit[i] = none[i] && req[i];
    assign none[i+1] = none[i] && !req[i];
  end

  assign valid = !none[N];

  always_comb begin
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        idx = IW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/rai_reset_irq.sv ***
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rai_reset_irq #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reset pin
  input wire logic reset_pin_n,
  // event sources
  input wire logic [rai_pkg::NSRC-1:rai_pkg::SRC_FIRST_MASK] periph_irq,
  input wire logic software_irq,
  input wire logic illegal_opcode_irq,
  input wire logic watchdog_overflow,
  input wire rai_pkg::rai_fetch_t fetch,
  // cpu core
  input wire rai_pkg::rai_ack_t cpu_ack,
  output rai_pkg::rai_irq_t cpu_irq,
  output logic cpu_rst,
  output logic watchdog_enable,
  output logic prescaler_clear
);
  import rai_pkg::*;

  localparam logic [4:0] MALF_LOAD = 5'(MALF_RST_CYC - 1);
  localparam logic [3:0] EXT_MIN = 4'(EXT_RST_MIN_CYC);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 32) begin : g_bad_depth
    $error("rai_reset_irq: STACK_DEPTH out of range");
  end
  if (MALF_RST_CYC < 2 || MALF_RST_CYC > 32 || EXT_RST_MIN_CYC > 15) begin : g_bad_time
    $error("rai_reset_irq: reset timing does not fit counters");
  end

  logic pin_s;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic imf_q;
  logic [NSRC-1:SRC_FIRST_MASK] ef_q;
  logic [NSRC-1:SRC_TRAP] lat_q;
  logic [NSRC-1:SRC_TRAP] lat_d;
  logic [NSRC-1:SRC_TRAP] lat_set;
  logic [CTL_W-1:0] ctl_q;
  logic [SYS_W-1:0] sys_q;
  logic [3:0] cause_q;
  logic [STACK_DEPTH-1:0] imf_stk_q;
  logic [4:0] malf_cnt_q;
  logic [3:0] ext_cnt_q;
  logic cpu_rst_q;
  logic presc_q;
  rai_irq_t irq_q;
  logic [IDX_W-1:0] irq_idx_q;
  logic [NSRC-1:0] cand;
  logic sel_valid;
  logic [IDX_W-1:0] sel_idx;

  // pin is asynchronous to clk
  rai_sync2 #(.RST_VAL(1'b1)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d(reset_pin_n),
    .q(pin_s)
  );

  // decode and events
  logic wr_fire;
  logic lat_we;
  logic en_we;
  logic ctl_we;
  logic sys_we;
  logic ext_hold;
  logic int_rst;
  logic trap_hit;
  logic trap_rst;
  logic trap_irq;
  logic wdt_rst;
  logic wdt_irq;
  logic clk_fault;
  logic malf_req;
  logic accept;
  logic [SYS_W-1:0] sys_new;

  assign wr_fire = avs_write && !wait_q;
  assign lat_we = wr_fire && (avs_address == REG_LATCH);
  assign en_we = wr_fire && (avs_address == REG_ENABLE);
  assign ctl_we = wr_fire && (avs_address == REG_CTRL);
  assign sys_we = wr_fire && (avs_address == REG_SYSCTL);
  assign sys_new = avs_writedata[SYS_W-1:0];

  assign ext_hold = !pin_s && (ext_cnt_q == EXT_MIN);
  assign int_rst = rst || ext_hold || (malf_cnt_q != 5'h00);

  // fetches are ignored while the core is held
  assign trap_hit = fetch.valid && !cpu_rst_q && (fetch.in_sfr || fetch.in_dbr ||
                    (fetch.in_ram && ctl_q[CTL_TRAP_RAM]));
  assign trap_rst = trap_hit && ctl_q[CTL_TRAP_ACT];
  assign trap_irq = trap_hit && !ctl_q[CTL_TRAP_ACT];
  assign wdt_rst = watchdog_overflow && !cpu_rst_q && ctl_q[CTL_WDT_ACT];
  assign wdt_irq = watchdog_overflow && !cpu_rst_q && !ctl_q[CTL_WDT_ACT];

  assign clk_fault = sys_we && (
    (sys_q[SYS_XEN] && sys_q[SYS_XTEN] && !sys_new[SYS_XEN] && !sys_new[SYS_XTEN]) ||
    (sys_q[SYS_XEN] && !sys_new[SYS_XEN] && !sys_q[SYS_SYSCK]) ||
    (sys_q[SYS_XTEN] && !sys_new[SYS_XTEN] && sys_q[SYS_SYSCK]));

  assign malf_req = trap_rst || wdt_rst || clk_fault;
  assign accept = cpu_ack.accept && irq_q.req && !int_rst;

  // bus slave: every access answers on the second edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_comb begin
    rd_word = '0;
    if (avs_address == REG_LATCH) begin
      rd_word[NSRC-1:SRC_TRAP] = lat_q;
    end else if (avs_address == REG_ENABLE) begin
      rd_word[NSRC-1:SRC_FIRST_MASK] = ef_q;
      rd_word[EN_IMF] = imf_q;
    end else if (avs_address == REG_CTRL) begin
      rd_word[CTL_W-1:0] = ctl_q;
    end else if (avs_address == REG_SYSCTL) begin
      rd_word[SYS_W-1:0] = sys_q;
    end else if (avs_address == REG_STATUS) begin
      rd_word[ST_REQ] = irq_q.req;
      rd_word[ST_LEVEL +: 5] = irq_q.level;
      rd_word[ST_CAUSE +: 4] = cause_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_word;
    end
  end

  // reset pin qualification
  always_ff @(posedge clk) begin
    if (rst || pin_s) begin
      ext_cnt_q <= 4'h0;
    end else if (ext_cnt_q != EXT_MIN) begin
      ext_cnt_q <= ext_cnt_q + 4'h1;
    end
  end

  // malfunction pulse; loaded at power-up as the circuit is not cleared then
  always_ff @(posedge clk) begin
    if (rst) begin
      malf_cnt_q <= MALF_LOAD;
    end else if (malf_req) begin
      malf_cnt_q <= MALF_LOAD;
    end else if (malf_cnt_q != 5'h00) begin
      malf_cnt_q <= malf_cnt_q - 5'h01;
    end
  end

  // core reset and prescaler clear; release lets the core fetch the top vector
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_rst_q <= 1'b1;
      presc_q <= 1'b1;
    end else begin
      cpu_rst_q <= int_rst || malf_req;
      presc_q <= int_rst || malf_req;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cause_q <= 4'h0;
    end else if (ext_hold || malf_req) begin
      cause_q <= {clk_fault, wdt_rst, trap_rst, ext_hold};
    end
  end

  // request latches; a new request beats any clear in the same cycle
  assign lat_set = {periph_irq, wdt_irq, trap_irq};
  for (genvar i = SRC_TRAP; i < NSRC; i++) begin : g_lat
    logic clr;
    assign clr = (lat_we && !avs_writedata[i]) ||
                 (accept && (irq_idx_q == IDX_W'(i)));
    assign lat_d[i] = lat_set[i] || (lat_q[i] && !clr);
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      lat_q <= '0;
    end else begin
      lat_q <= lat_d;
    end
  end

  // master enable and its stack; hardware acceptance beats a software write
  always_ff @(posedge clk) begin
    if (int_rst) begin
      imf_q <= 1'b0;
    end else if (accept) begin
      imf_q <= 1'b0;
    end else if (cpu_ack.reti) begin
      imf_q <= imf_stk_q[0];
    end else if (en_we) begin
      imf_q <= avs_writedata[EN_IMF];
    end
  end

  // stack overflow drops the oldest entry
  always_ff @(posedge clk) begin
    if (int_rst) begin
      imf_stk_q <= '0;
    end else if (accept) begin
      imf_stk_q <= {imf_stk_q[STACK_DEPTH-2:0], imf_q};
    end else if (cpu_ack.reti) begin
      imf_stk_q <= {1'b0, imf_stk_q[STACK_DEPTH-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      ef_q <= '0;
    end else if (en_we) begin
      ef_q <= avs_writedata[NSRC-1:SRC_FIRST_MASK];
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      ctl_q <= CTL_RESET;
    end else if (ctl_we) begin
      ctl_q <= avs_writedata[CTL_W-1:0];
    end
  end

  // a faulting write is not stored, reset restores defaults anyway
  always_ff @(posedge clk) begin
    if (int_rst) begin
      sys_q <= SYS_RESET;
    end else if (sys_we && !clk_fault) begin
      sys_q <= sys_new;
    end
  end

  // candidates: soft and illegal opcode share one unlatched slot
  always_comb begin
    cand = '0;
    cand[SRC_SOFT] = software_irq || illegal_opcode_irq;
    cand[SRC_WDT:SRC_TRAP] = lat_q[SRC_WDT:SRC_TRAP];
    cand[NSRC-1:SRC_FIRST_MASK] = lat_q[NSRC-1:SRC_FIRST_MASK] & ef_q &
                                  {(NSRC - SRC_FIRST_MASK){imf_q}};
    cand[SRC_EXT0] = cand[SRC_EXT0] && ctl_q[CTL_EXT0_EN];
  end

  rai_prio #(.N(NSRC), .IW(IDX_W)) u_prio (
    .req(cand),
    .valid(sel_valid),
    .idx(sel_idx)
  );

  function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
    if (idx == IDX_W'(SRC_SOFT)) begin
      vec_of = VEC_SOFT;
    end else if (idx == IDX_W'(SRC_TRAP)) begin
      vec_of = VEC_TRAP;
    end else if (idx == IDX_W'(SRC_WDT)) begin
      vec_of = VEC_WDT;
    end else if (idx < IDX_W'(SRC_HI_FIRST)) begin
      vec_of = VEC_LO_BASE - 16'((int'(idx) - SRC_FIRST_MASK) * 2);
    end else begin
      vec_of = VEC_HI_BASE - 16'((int'(idx) - SRC_HI_FIRST) * 2);
    end
  endfunction

  // presented request is frozen until the core takes it
  always_ff @(posedge clk) begin
    if (int_rst) begin
      irq_q.req <= 1'b0;
      irq_q.nmi <= 1'b1;
      irq_q.level <= LEVEL_RESET;
      irq_q.vector <= VEC_RESET;
      irq_idx_q <= '0;
    end else if (irq_q.req && !cpu_ack.accept) begin
      irq_q <= irq_q;
    end else if (accept) begin
      irq_q.req <= 1'b0;
    end else begin
      irq_q.req <= sel_valid;
      irq_q.nmi <= sel_idx < IDX_W'(SRC_FIRST_MASK);
      irq_q.level <= (sel_idx < IDX_W'(SRC_FIRST_MASK)) ? LEVEL_NMI :
                     5'(int'(sel_idx) + 1);
      irq_q.vector <= vec_of(sel_idx);
      irq_idx_q <= sel_idx;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign cpu_irq = irq_q;
  assign cpu_rst = cpu_rst_q;
  assign watchdog_enable = ctl_q[CTL_WDT_EN];
  assign prescaler_clear = presc_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_MALF_PULSE: assert property (malf_req |=> cpu_rst_q && malf_cnt_q == MALF_LOAD)
    else $error("malfunction reset not started");
  AST_MALF_END: assert property (malf_cnt_q == 5'h01 && !malf_req && !ext_hold && !rst ##1
                                 !malf_req && !ext_hold |=> !cpu_rst_q)
    else $error("malfunction reset overran");
  AST_POWERUP: assert property ($past(rst) && !rst |-> cpu_rst_q)
    else $error("no reset right after power-up");
  AST_RESET_CLEARS: assert property (ext_hold |=> !imf_q && ef_q == '0 && lat_q == '0 &&
                                     watchdog_enable && prescaler_clear)
    else $error("reset left state behind");
  AST_EXT_MIN: assert property (ext_hold |-> $past(!pin_s, 12))
    else $error("pin reset applied too early");
  AST_TRAP_IRQ: assert property (trap_irq && !int_rst |=> lat_q[SRC_TRAP])
    else $error("trap interrupt not latched");
  AST_WDT_IRQ: assert property (wdt_irq && !int_rst |=> lat_q[SRC_WDT])
    else $error("watchdog interrupt not latched");
  AST_CLK_FAULT: assert property (clk_fault |=> cpu_rst_q ##1 cpu_rst_q)
    else $error("clock fault did not reset");
  AST_MASKED: assert property ($rose(irq_q.req) && !irq_q.nmi |-> $past(imf_q))
    else $error("maskable taken without master enable");
  AST_HOLD: assert property (irq_q.req && !cpu_ack.accept && !int_rst ##1 !int_rst
                             |-> irq_q.req && $stable(irq_q.vector))
    else $error("presented request changed before acceptance");
  AST_ACCEPT: assert property (accept |=> !imf_q && imf_stk_q[0] == $past(imf_q) &&
                               (irq_q.nmi || !irq_q.req))
    else $error("master enable not pushed on acceptance");
  AST_LEVEL: assert property (irq_q.req && !irq_q.nmi |->
                              irq_q.level == 5'(int'(irq_idx_q) + 1))
    else $error("maskable level wrong");
endmodule
`default_nettype wire

// *** verification/rai_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rai_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller side
  input wire rai_pkg::rai_irq_t cpu_irq,
  input wire logic cpu_rst,
  output var rai_pkg::rai_ack_t cpu_ack,
  // bench control, ack_dly 0 answers at once
  input wire logic [3:0] ack_dly,
  input wire logic reti_cmd
);
  import rai_pkg::*;
  logic [3:0] wait_q;
  logic busy_q;
  // one accept per request; skip the cycle in which the request drops
  always_ff @(posedge clk) begin
    cpu_ack.reti <= reti_cmd;
    cpu_ack.accept <= 1'b0;
    if (rst || cpu_rst) begin
      wait_q <= 4'h0;
      busy_q <= 1'b0;
    end else if (busy_q) begin
      busy_q <= 1'b0;
    end else if (cpu_irq.req && wait_q >= ack_dly) begin
      cpu_ack.accept <= 1'b1;
      busy_q <= 1'b1;
      wait_q <= 4'h0;
    end else if (cpu_irq.req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** verification/rai_reset_irq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b,m) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %s", $time, m); end end
module rai_reset_irq_tb_top;
  import rai_pkg::*;
  typedef struct {int src; logic [31:0] ctl; logic [31:0] en; logic rq;
    logic [15:0] vec; logic [4:0] lvl;} rai_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic reset_pin_n = 1'b1;
  logic [23:4] periph_irq = '0;
  logic software_irq = 1'b0;
  logic illegal_opcode_irq = 1'b0;
  logic watchdog_overflow = 1'b0;
  rai_fetch_t fetch = '0;
  rai_ack_t cpu_ack;
  rai_irq_t cpu_irq;
  logic cpu_rst, watchdog_enable, prescaler_clear;
  logic [3:0] ack_dly = 4'h2;
  logic reti_cmd = 1'b0;
  logic [31:0] rd;
  logic [15:0] ev;
  int err_total = 0;
  int n_checks = 0;
  int n;
  // source, control, enables, expected request, vector, level
  rai_row_t rows [8] = '{
    '{4, 32'h0000_001E, 32'h0000_0011, 1'b1, 16'hFFF6, 5'h05},
    '{4, 32'h0000_0016, 32'h0000_0011, 1'b0, 16'h0000, 5'h00},
    '{5, 32'h0000_0016, 32'h0000_0020, 1'b0, 16'h0000, 5'h00},
    '{5, 32'h0000_0016, 32'h0000_0021, 1'b1, 16'hFFF4, 5'h06},
    '{9, 32'h0000_0016, 32'h0000_0001, 1'b0, 16'h0000, 5'h00},
    '{15, 32'h0000_0016, 32'h0000_8001, 1'b1, 16'hFFE0, 5'h10},
    '{16, 32'h0000_0016, 32'h0001_0001, 1'b1, 16'hFFBE, 5'h11},
    '{23, 32'h0000_0016, 32'h0080_0001, 1'b1, 16'hFFB0, 5'h18}};

  always #5 clk = ~clk;

  rai_reset_irq rai_reset_irq_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_pin_n(reset_pin_n), .periph_irq(periph_irq), .software_irq(software_irq),
    .illegal_opcode_irq(illegal_opcode_irq), .watchdog_overflow(watchdog_overflow),
    .fetch(fetch), .cpu_ack(cpu_ack), .cpu_irq(cpu_irq), .cpu_rst(cpu_rst),
    .watchdog_enable(watchdog_enable), .prescaler_clear(prescaler_clear));

  rai_core_model rai_core_model_i (.clk(clk), .rst(rst), .cpu_irq(cpu_irq),
    .cpu_rst(cpu_rst), .cpu_ack(cpu_ack), .ack_dly(ack_dly), .reti_cmd(reti_cmd));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) err_total++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rd, e, "register read")
  endtask

  task automatic drv(input logic [31:0] m);
    periph_irq <= m[23:4];
  endtask

  task automatic wait_req();
    n = 0;
    while (cpu_irq.req !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
  endtask

  // soft sources are levels, dropped at the edge that takes the accept
  task automatic wait_acc();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_ack.accept !== 1'b1 && n < 40);
    if (cpu_ack.accept !== 1'b1) err_total++;
    software_irq <= 1'b0;
    illegal_opcode_irq <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reti();
    @(posedge clk);
    reti_cmd <= 1'b1;
    @(posedge clk);
    reti_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    #200_000;
    err_total++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(cpu_rst, 1'b1, "power-up pulse")
    n = 0;
    while (cpu_rst !== 1'b0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    `CHK(cpu_rst, 1'b0, "power-up release")
    `CHK(watchdog_enable, 1'b1, "watchdog enable")
    rdc(REG_CTRL, 32'(CTL_RESET));
    rdc(REG_SYSCTL, 32'(SYS_RESET));
    rdc(REG_LATCH, 32'h0000_0000);
    rdc(REG_ENABLE, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(REG_CTRL, rows[i].ctl);
      wr(REG_ENABLE, rows[i].en);
      @(posedge clk);
      drv(32'h1 << rows[i].src);
      @(posedge clk);
      drv(32'h0);
      wait_req();
      `CHK(cpu_irq.req, rows[i].rq, "request")
      if (rows[i].rq) begin
        `CHK(cpu_irq.vector, rows[i].vec, "vector")
        `CHK(cpu_irq.level, rows[i].lvl, "level")
        `CHK(cpu_irq.nmi, 1'b0, "maskable")
        wait_acc();
        rdc(REG_LATCH, 32'h0000_0000);
        rdc(REG_ENABLE, rows[i].en & ~32'h1);
        reti();
        rdc(REG_ENABLE, rows[i].en);
      end else begin
        rdc(REG_LATCH, 32'h1 << rows[i].src);
        wr(REG_LATCH, 32'hFFFF_FFFF);
        rdc(REG_LATCH, 32'h1 << rows[i].src);
        wr(REG_LATCH, 32'h0000_0000);
        rdc(REG_LATCH, 32'h0000_0000);
      end
    end
    // simultaneous pair, then nesting inside the lower service
    ack_dly <= 4'hF;
    wr(REG_ENABLE, 32'h0000_0241);
    @(posedge clk);
    drv(32'h0000_0240);
    @(posedge clk);
    drv(32'h0);
    wait_req();
    `CHK(cpu_irq.vector, 16'hFFF2, "first winner")
    wait_acc();
    `CHK(cpu_irq.req, 1'b0, "master cleared")
    reti();
    wait_req();
    `CHK(cpu_irq.vector, 16'hFFEC, "second winner")
    wait_acc();
    wr(REG_ENABLE, 32'h0000_0241);
    @(posedge clk);
    drv(32'h0000_0040);
    @(posedge clk);
    drv(32'h0);
    wait_req();
    `CHK(cpu_irq.vector, 16'hFFF2, "nested")
    wait_acc();
    reti();
    reti();
    // converter request lands while a lower one is accepted
    ack_dly <= 4'h0;
    wr(REG_ENABLE, 32'h0010_8001);
    @(posedge clk);
    drv(32'h0010_0000);
    @(posedge clk);
    drv(32'h0);
    repeat (2) @(posedge clk);
    drv(32'h0000_8000);
    @(posedge clk);
    drv(32'h0);
    repeat (4) @(posedge clk);
    reti();
    wait_req();
    `CHK(cpu_irq.vector, 16'hFFE0, "converter kept")
    wait_acc();
    reti();
    ack_dly <= 4'h2;
    // non-maskables with master enable off; ram fetch without select must not trap
    wr(REG_ENABLE, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0010);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      case (k)
        0: fetch <= 4'hC;
        1: fetch <= 4'hA;
        2: watchdog_overflow <= 1'b1;
        3: software_irq <= 1'b1;
        4: illegal_opcode_irq <= 1'b1;
        default: fetch <= 4'h9;
      endcase
      @(posedge clk);
      fetch <= '0;
      watchdog_overflow <= 1'b0;
      wait_req();
      `CHK(cpu_irq.req, k < 5, "nmi request")
      if (k < 5) begin
        ev = (k < 2) ? VEC_TRAP : ((k == 2) ? VEC_WDT : VEC_SOFT);
        `CHK(cpu_irq.vector, ev, "nmi vector")
        `CHK(cpu_irq.nmi, 1'b1, "nmi flag")
        `CHK(cpu_irq.level, LEVEL_NMI, "nmi level")
        wait_acc();
        rdc(REG_LATCH, 32'h0000_0000);
        reti();
      end
    end
    // malfunction resets: trap, ram trap, watchdog, three clock faults
    for (int k = 0; k < 6; k++) begin
      wr(REG_CTRL, (k == 1) ? 32'h0000_0017 : 32'h0000_0016);
      wr(REG_ENABLE, 32'h0000_0031);
      if (k > 3) wr(REG_SYSCTL, 32'h0000_0003);
      if (k == 5) wr(REG_SYSCTL, 32'h0000_0007);
      @(posedge clk);
      fetch <= (k == 0) ? 4'hC : (k == 1) ? 4'h9 : 4'h0;
      watchdog_overflow <= (k == 2);
      @(posedge clk);
      fetch <= '0;
      watchdog_overflow <= 1'b0;
      if (k > 2) wr(REG_SYSCTL, (k == 5) ? 32'h0000_0005 : 32'h0000_0000);
      n = 0;
      while (cpu_rst !== 1'b1 && n < 6) begin
        @(posedge clk);
        n++;
      end
      `CHK(prescaler_clear, 1'b1, "prescaler cleared")
      n = 0;
      while (cpu_rst === 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      `CHK(n > 0 && n <= MALF_RST_CYC, 1'b1, "reset span")
      rdc(REG_ENABLE, 32'h0000_0000);
      rdc(REG_CTRL, 32'(CTL_RESET));
      // status keeps the cause of the last reset
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      `CHK(rd[ST_CAUSE +: 4], (k < 2) ? 4'h2 : ((k == 2) ? 4'h4 : 4'h8), "cause")
      `CHK(rd[ST_REQ], 1'b0, "no request after reset")
    end
    // pin pulses: one below the minimum, one well above it
    wr(REG_ENABLE, 32'h0000_0011);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(REG_ENABLE, 32'h0000_0011);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(cpu_rst, 1'b1, "pin reset")
    `CHK(cpu_irq.vector, VEC_RESET, "reset vector")
    reset_pin_n <= 1'b1;
    n = 0;
    while (cpu_rst !== 1'b0 && n < 8) begin
      @(posedge clk);
      n++;
    end
    `CHK(cpu_rst, 1'b0, "pin release")
    rdc(REG_ENABLE, 32'h0000_0000);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK(rd[ST_CAUSE +: 4], 4'h1, "pin cause")
    end_sim;
  end
endmodule
`default_nettype wire
